//--- verilog/spr_pkg.sv
package spr_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFF_MAIN_CONTROL = 6'h00;
  localparam logic [5:0] OFF_FRAME_CONTROL = 6'h04;
  localparam logic [5:0] OFF_BIT_RATE = 6'h0C;
  localparam logic [5:0] OFF_IRQ_ENABLE_CLEAR = 6'h14;
  localparam logic [5:0] OFF_IRQ_ENABLE_SET = 6'h16;
  localparam logic [5:0] OFF_IRQ_FLAGS = 6'h18;
  localparam logic [5:0] OFF_LINK_STATUS = 6'h1A;
  localparam logic [5:0] OFF_SYNC_PENDING = 6'h1C;
  localparam logic [5:0] OFF_MATCH_ADDRESS = 6'h24;
  localparam logic [5:0] OFF_SHIFT_DATA = 6'h28;
  localparam logic [5:0] OFF_DEBUG_HALT = 6'h30;

  // ==========================================================
  // Implemented-bit masks, reserved bits read as zero
  localparam logic [31:0] MC_MASK = 32'h7F33_019F;
  localparam logic [31:0] FC_MASK = 32'h0002_E247;
  localparam logic [31:0] MATCH_MASK = 32'h00FF_00FF;
  localparam logic [7:0] IRQ_MASK = 8'h8F;
  localparam logic [15:0] STATUS_MASK = 16'h0004;

  // ==========================================================
  // Field positions
  localparam int MC_SOFT_RESET_BIT = 0;
  localparam int MC_ENABLE_BIT = 1;
  localparam int MC_MODE_LSB = 2;
  localparam int MC_BIT_ORDER_BIT = 30;
  localparam int FC_RECEIVER_EN_BIT = 17;
  localparam int STATUS_OVERFLOW_BIT = 2;

  // Sync-pending bit positions
  localparam int SB_SOFT_RESET = 0;
  localparam int SB_ENABLE = 1;
  localparam int SB_FRAME = 2;
  localparam int SB_COUNT = 3;

  // Operating modes of the serial interface
  localparam logic [2:0] MODE_SPI_SLAVE = 3'h2;
  localparam logic [2:0] MODE_SPI_MASTER = 3'h3;

  // Core-domain crossing latency in clock cycles
  localparam int SYNC_CYCLES = 3;

  // ==========================================================
  // Reset values
  localparam logic [31:0] MC_RESET = 32'h0000_0000;
  localparam logic [31:0] FC_RESET = 32'h0000_0000;
  localparam logic [7:0] BIT_RATE_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
  localparam logic [8:0] DATA_RESET = 9'h000;
  localparam logic DEBUG_RESET = 1'b0;

  // ==========================================================
  // State of the register bank
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] frame;
    logic [7:0] baud;
    logic [7:0] irq_en;
    logic [7:0] flags;
    logic [15:0] status;
    logic [31:0] match;
    logic [8:0] tx_data;
    logic tx_load;
    logic dbg;
    logic core_en;
    logic core_receiver_en;
    logic [31:0] rdata;
  } spr_regs_type;

  localparam spr_regs_type SPR_REGS_RESET = '{
    ctrl: MC_RESET, frame: FC_RESET, baud: BIT_RATE_RESET,
    irq_en: IRQ_ENABLE_RESET, flags: IRQ_FLAGS_RESET,
    status: STATUS_RESET, match: MATCH_RESET, tx_data: DATA_RESET,
    tx_load: 1'b0, dbg: DEBUG_RESET, core_en: 1'b0, core_receiver_en: 1'b0,
    rdata: 32'h0000_0000};

  // ==========================================================
  // Word hit on a byte offset
  function automatic logic spr_hit(input logic [5:0] addr,
                                   input logic [5:0] off);
    return addr[5:2] == off[5:2];
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] spr_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb,
                                            input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res & mask;
  endfunction

endpackage

//--- verilog/spr_sync_stage.sv
`timescale 1ns/1ns
// ============================================================
// Crossing stage: busy for DEPTH cycles, done pulse at the end
module spr_sync_stage import spr_pkg::*; #(
  parameter int DEPTH = SYNC_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Operation
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  typedef struct packed {
    logic [3:0] cnt;
  } spr_sync_type;

  spr_sync_type s_ff;
  spr_sync_type nxt_s;

  // Countdown of the crossing
  always_comb begin
    nxt_s = s_ff;
    if (start_i) begin
      nxt_s.cnt = 4'(DEPTH);
    end else if (s_ff.cnt != 4'h0) begin
      nxt_s.cnt = s_ff.cnt - 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Status outputs
  assign busy_o = s_ff.cnt != 4'h0;
  assign done_o = s_ff.cnt == 4'h1;

endmodule

//--- verilog/spr_regmap.sv
`timescale 1ns/1ns
module spr_regmap import spr_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Peripheral bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [5:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Access protection unit
  input wire logic protect_i,
  // Events from the shifter
  input wire logic [7:0] flag_set_i,
  input wire logic overflow_set_i,
  input wire logic [8:0] rx_data_i,
  // Configuration towards the shifter
  output logic [31:0] ctrl_o,
  output logic [31:0] frame_o,
  output logic [7:0] baud_o,
  output logic [31:0] match_o,
  output logic [7:0] irq_enable_o,
  output logic bit_order_o,
  output logic spi_mode_o,
  output logic halt_in_debug_o,
  output logic core_enable_o,
  output logic core_rx_enable_o,
  output logic [8:0] tx_data_o,
  output logic tx_load_o
);

  spr_regs_type r_ff;
  spr_regs_type nxt_regs;
  logic [SB_COUNT-1:0] sync_busy;
  logic [SB_COUNT-1:0] sync_done;
  logic [SB_COUNT-1:0] sync_start;
  logic acc_wr;
  logic rd_setup;
  logic bus_err;
  logic wr_ok;
  logic prot;
  logic [31:0] read_word;
  logic [31:0] new_ctrl;
  logic [31:0] new_frame;
  logic [7:0] flag_clr;
  logic [15:0] status_clr;
  logic hit_mc;
  logic hit_fc;

  // ==========================================================
  // Bus decode
  assign acc_wr = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign hit_mc = spr_hit(paddr_i, OFF_MAIN_CONTROL);
  assign hit_fc = spr_hit(paddr_i, OFF_FRAME_CONTROL);

  // ==========================================================
  // Crossing stages: soft reset, enable, frame control
  for (genvar g = 0; g < SB_COUNT; g++) begin : g_sync
    spr_sync_stage #(.DEPTH(SYNC_CYCLES)) u_stage (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(sync_start[g]),
      .busy_o(sync_busy[g]),
      .done_o(sync_done[g])
    );
  end

  // ==========================================================
  // Read multiplexer
  always_comb begin
    read_word = 32'h0000_0000;
    if (spr_hit(paddr_i, OFF_MAIN_CONTROL)) begin
      read_word = r_ff.ctrl & MC_MASK;
    end else if (spr_hit(paddr_i, OFF_FRAME_CONTROL)) begin
      read_word = r_ff.frame & FC_MASK;
    end else if (spr_hit(paddr_i, OFF_BIT_RATE)) begin
      read_word = {24'h00_0000, r_ff.baud};
    end else if (spr_hit(paddr_i, OFF_IRQ_ENABLE_CLEAR)) begin
      read_word = {8'h00, r_ff.irq_en, 8'h00, r_ff.irq_en};
    end else if (spr_hit(paddr_i, OFF_IRQ_FLAGS)) begin
      read_word = {r_ff.status, 8'h00, r_ff.flags};
    end else if (spr_hit(paddr_i, OFF_SYNC_PENDING)) begin
      read_word = {29'h0000_0000, sync_busy};
    end else if (spr_hit(paddr_i, OFF_MATCH_ADDRESS)) begin
      read_word = r_ff.match;
    end else if (spr_hit(paddr_i, OFF_SHIFT_DATA)) begin
      read_word = {23'h00_0000, rx_data_i};
    end else if (spr_hit(paddr_i, OFF_DEBUG_HALT)) begin
      read_word = {31'h0000_0000, r_ff.dbg};
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_regs = r_ff;
    nxt_regs.tx_load = 1'b0;
    sync_start = '0;
    flag_clr = 8'h00;
    status_clr = 16'h0000;
    if (rd_setup) begin
      nxt_regs.rdata = read_word;
    end
    // repeat while pending is an error
    bus_err = acc_wr & (sync_busy[SB_SOFT_RESET] |
              (hit_mc & sync_busy[SB_ENABLE]) |
              (hit_fc & sync_busy[SB_FRAME]));
    wr_ok = acc_wr & ~bus_err;
    prot = protect_i & (hit_mc | hit_fc |
           spr_hit(paddr_i, OFF_BIT_RATE) |
           spr_hit(paddr_i, OFF_IRQ_ENABLE_CLEAR) |
           spr_hit(paddr_i, OFF_MATCH_ADDRESS) |
           spr_hit(paddr_i, OFF_DEBUG_HALT));
    new_ctrl = spr_merge(r_ff.ctrl, pwdata_i, pstrb_i, MC_MASK);
    new_frame = spr_merge(r_ff.frame, pwdata_i, pstrb_i, FC_MASK);
    // enabled: only enable, receiver enable and soft reset move
    if (r_ff.ctrl[MC_ENABLE_BIT]) begin
      new_ctrl = r_ff.ctrl;
      if (pstrb_i[0]) begin
        new_ctrl[MC_ENABLE_BIT] = pwdata_i[MC_ENABLE_BIT];
      end
      new_frame = r_ff.frame;
      if (pstrb_i[2]) begin
        new_frame[FC_RECEIVER_EN_BIT] = pwdata_i[FC_RECEIVER_EN_BIT];
      end
    end
    if (wr_ok && !prot) begin
      if (hit_mc) begin
        if (pstrb_i[0] && pwdata_i[MC_SOFT_RESET_BIT]) begin
          // soft reset wins over the rest
          nxt_regs = SPR_REGS_RESET;
          nxt_regs.dbg = r_ff.dbg;
          nxt_regs.core_en = r_ff.core_en;
          nxt_regs.core_receiver_en = r_ff.core_receiver_en;
          nxt_regs.ctrl[MC_SOFT_RESET_BIT] = 1'b1;
          sync_start[SB_SOFT_RESET] = 1'b1;
        end else begin
          nxt_regs.ctrl = new_ctrl;
          sync_start[SB_ENABLE] = new_ctrl[MC_ENABLE_BIT] !=
                                  r_ff.ctrl[MC_ENABLE_BIT];
        end
      end else if (hit_fc) begin
        nxt_regs.frame = new_frame;
        sync_start[SB_FRAME] = new_frame[FC_RECEIVER_EN_BIT] !=
                               r_ff.frame[FC_RECEIVER_EN_BIT];
      end else if (spr_hit(paddr_i, OFF_BIT_RATE)) begin
        if (pstrb_i[0]) begin
          nxt_regs.baud = pwdata_i[7:0];
        end
      end else if (spr_hit(paddr_i, OFF_IRQ_ENABLE_CLEAR)) begin
        // one clears on low lane, one sets on high lane
        if (pstrb_i[0]) begin
          nxt_regs.irq_en = nxt_regs.irq_en & ~pwdata_i[7:0];
        end
        if (pstrb_i[2]) begin
          nxt_regs.irq_en = (nxt_regs.irq_en | pwdata_i[23:16]) &
                            IRQ_MASK;
        end
      end else if (spr_hit(paddr_i, OFF_MATCH_ADDRESS)) begin
        nxt_regs.match = spr_merge(r_ff.match, pwdata_i, pstrb_i,
                                   MATCH_MASK);
      end else if (spr_hit(paddr_i, OFF_DEBUG_HALT)) begin
        if (pstrb_i[0]) begin
          nxt_regs.dbg = pwdata_i[0];
        end
      end
    end
    // Unprotected registers: flags, status, data
    if (wr_ok && spr_hit(paddr_i, OFF_IRQ_FLAGS)) begin
      flag_clr = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
      status_clr = {pstrb_i[3] ? pwdata_i[31:24] : 8'h00,
                    pstrb_i[2] ? pwdata_i[23:16] : 8'h00};
    end
    if (wr_ok && spr_hit(paddr_i, OFF_SHIFT_DATA) &&
        !sync_start[SB_SOFT_RESET]) begin
      nxt_regs.tx_data = 9'(spr_merge({23'h00_0000, r_ff.tx_data},
                                      pwdata_i, pstrb_i,
                                      32'h0000_01FF));
      nxt_regs.tx_load = 1'b1;
    end
    // Sticky events: set wins over clear
    nxt_regs.flags = ((nxt_regs.flags & ~flag_clr) | flag_set_i) &
                     IRQ_MASK;
    nxt_regs.status = (nxt_regs.status & ~status_clr) & STATUS_MASK;
    if (overflow_set_i) begin
      nxt_regs.status[STATUS_OVERFLOW_BIT] = 1'b1;
    end
    // core copies update at end of crossing
    if (sync_done[SB_ENABLE]) begin
      nxt_regs.core_en = r_ff.ctrl[MC_ENABLE_BIT];
    end
    if (sync_done[SB_FRAME]) begin
      nxt_regs.core_receiver_en = r_ff.frame[FC_RECEIVER_EN_BIT];
    end
    // soft reset completes, core side disabled
    if (sync_done[SB_SOFT_RESET]) begin
      nxt_regs.ctrl[MC_SOFT_RESET_BIT] = 1'b0;
      nxt_regs.core_en = 1'b0;
      nxt_regs.core_receiver_en = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= SPR_REGS_RESET;
    end else begin
      r_ff <= nxt_regs;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_o = r_ff.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = bus_err;
  assign ctrl_o = r_ff.ctrl;
  assign frame_o = r_ff.frame;
  assign baud_o = r_ff.baud;
  assign match_o = r_ff.match;
  assign irq_enable_o = r_ff.irq_en;
  assign bit_order_o = r_ff.ctrl[MC_BIT_ORDER_BIT];
  // valid only for slave or master code
  assign spi_mode_o = (r_ff.ctrl[MC_MODE_LSB +: 3] == MODE_SPI_SLAVE) |
                      (r_ff.ctrl[MC_MODE_LSB +: 3] == MODE_SPI_MASTER);
  assign halt_in_debug_o = r_ff.dbg;
  assign core_enable_o = r_ff.core_en;
  assign core_rx_enable_o = r_ff.core_receiver_en;
  assign tx_data_o = r_ff.tx_data;
  assign tx_load_o = r_ff.tx_load;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_en_write;
    wr_ok && !prot && hit_mc && pstrb_i[0] && !pwdata_i[0] &&
    (pwdata_i[MC_ENABLE_BIT] != r_ff.ctrl[MC_ENABLE_BIT]);
  endsequence
  sequence s_en_crossing;
    sync_busy[SB_ENABLE] ##[1:8] !sync_busy[SB_ENABLE];
  endsequence

  property p_byte_lane;
    acc_wr && !bus_err && !protect_i && hit_fc && pstrb_i == 4'h1
    |=> $stable(frame_o[31:8]);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte write changed other lanes");

  property p_prot_hold;
    acc_wr && protect_i && spr_hit(paddr_i, OFF_BIT_RATE)
    |=> $stable(baud_o);
  endproperty
  a_prot_hold: assert property (p_prot_hold)
    else $error("protected register changed");

  property p_en_sync;
    s_en_write |=> s_en_crossing ##0 (core_enable_o == ctrl_o[1]);
  endproperty
  a_en_sync: assert property (p_en_sync)
    else $error("enable did not cross over");

  property p_ep_hold;
    acc_wr && hit_mc && ctrl_o[MC_ENABLE_BIT] && !pwdata_i[0]
    |=> $stable(ctrl_o[30:2]);
  endproperty
  a_ep_hold: assert property (p_ep_hold)
    else $error("enable-protected field changed");

  property p_reset_val;
    $fell(rst_i) |-> ctrl_o == MC_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("main control not reset");

  property p_bit31_zero;
    rd_setup && hit_mc |=> prdata_o[31] == 1'b0;
  endproperty
  a_bit31_zero: assert property (p_bit31_zero)
    else $error("reserved bit 31 read nonzero");

  property p_soft_reset;
    wr_ok && !prot && hit_mc && pstrb_i[0] && pwdata_i[0]
    |=> ctrl_o == 32'h0000_0001 ##[1:8] ctrl_o[0] == 1'b0;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset sequence wrong");

  property p_busy_err;
    acc_wr && hit_fc && sync_busy[SB_FRAME] |-> pslverr_o;
  endproperty
  a_busy_err: assert property (p_busy_err)
    else $error("no error on busy sync write");

  property p_w1s;
    wr_ok && !prot && spr_hit(paddr_i, OFF_IRQ_ENABLE_SET) &&
    pstrb_i == 4'h4
    |=> (irq_enable_o & ($past(pwdata_i[23:16]) & IRQ_MASK)) ==
        ($past(pwdata_i[23:16]) & IRQ_MASK);
  endproperty
  a_w1s: assert property (p_w1s)
    else $error("enable-set write did not enable");

  property p_rsv_read;
    rd_setup && spr_hit(paddr_i, 6'h08) |=> prdata_o == 32'h0000_0000;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved offset read nonzero");

endmodule

//--- test/test_spr_regmap.sv
`timescale 1ns/1ns
module test_spr_regmap;
  import spr_pkg::*;

  // ==========================================================
  // Bench signals
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, protect_i;
  logic overflow_set_i;
  logic [5:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0] pstrb_i;
  logic [7:0] flag_set_i;
  logic [8:0] rx_data_i;
  logic [31:0] prdata_o, ctrl_o, frame_o, match_o;
  logic [7:0] baud_o, irq_enable_o;
  logic pready_o, pslverr_o, bit_order_o, spi_mode_o, halt_in_debug_o;
  logic core_enable_o, core_rx_enable_o, tx_load_o;
  logic [8:0] tx_data_o;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [5:0] offs [10] = '{6'h00, 6'h04, 6'h0C, 6'h14, 6'h18, 6'h1C,
                            6'h24, 6'h28, 6'h30, 6'h08};

  spr_regmap spr_regmap_i (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .protect_i(protect_i), .flag_set_i(flag_set_i),
    .overflow_set_i(overflow_set_i), .rx_data_i(rx_data_i),
    .ctrl_o(ctrl_o), .frame_o(frame_o), .baud_o(baud_o), .match_o(match_o),
    .irq_enable_o(irq_enable_o), .bit_order_o(bit_order_o),
    .spi_mode_o(spi_mode_o), .halt_in_debug_o(halt_in_debug_o),
    .core_enable_o(core_enable_o), .core_rx_enable_o(core_rx_enable_o),
    .tx_data_o(tx_data_o), .tx_load_o(tx_load_o)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // Compare, bus tasks and closing report
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Two-phase write, error flag looked at in the access cycle
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= 1'b1;
    penable_i <= 1'b0;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(negedge clk_i);
    chk("bus error", {31'h0, e}, {31'h0, pslverr_o});
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    pwrite_i <= 1'b0;
  endtask

  // Two-phase read, data taken in the access cycle
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= 1'b0;
    penable_i <= 1'b0;
    paddr_i <= a;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(negedge clk_i);
    chk("ready", 32'h1, {31'h0, pready_o});
    chk("read data", exp, prdata_o);
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 6'h00;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'h0;
    protect_i = 1'b0;
    flag_set_i = 8'h00;
    overflow_set_i = 1'b0;
    rx_data_i = 9'h000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, reserved words included
    foreach (offs[i]) rd(offs[i], 32'h0000_0000);
    wr(6'h08, 32'hFFFF_FFFF, 4'hF, 1'b0);
    rd(6'h08, 32'h0000_0000);
    // Single lanes of a word register
    wr(6'h24, 32'hFFAB_FFFF, 4'b0100, 1'b0);
    wr(6'h24, 32'h0000_0012, 4'b0001, 1'b0);
    rd(6'h24, 32'h00AB_0012);
    chk("match", 32'h00AB_0012, match_o);
    // Protected register refuses, reads still served
    wr(6'h0C, 32'h0000_0055, 4'b0001, 1'b0);
    protect_i <= 1'b1;
    wr(6'h0C, 32'h0000_00AA, 4'b0001, 1'b0);
    rd(6'h0C, 32'h0000_0055);
    protect_i <= 1'b0;
    wr(6'h0C, 32'h0000_00AA, 4'b0001, 1'b0);
    #1;
    chk("baud", 32'h0000_00AA, {24'h0, baud_o});
    // Interrupt enable set and clear lanes
    wr(6'h16, 32'h008F_0000, 4'b0100, 1'b0);
    wr(6'h14, 32'h0000_0003, 4'b0001, 1'b0);
    wr(6'h16, 32'h0000_0000, 4'b0100, 1'b0);
    rd(6'h14, 32'h008C_008C);
    chk("irq enable", 32'h0000_008C, {24'h0, irq_enable_o});
    // Event flags set by pulses, cleared by one
    flag_set_i <= 8'hFF;
    overflow_set_i <= 1'b1;
    @(posedge clk_i);
    flag_set_i <= 8'h00;
    overflow_set_i <= 1'b0;
    rd(6'h18, 32'h0004_008F);
    wr(6'h18, 32'h0004_000F, 4'b0101, 1'b0);
    rd(6'h18, 32'h0000_0080);
    // Data register, half-word write and receive read
    wr(6'h28, 32'h0000_01A5, 4'b0011, 1'b0);
    #1;
    chk("tx data", 32'h0000_01A5, {23'h0, tx_data_o});
    chk("tx load", 32'h1, {31'h0, tx_load_o});
    rx_data_i <= 9'h1C3;
    rd(6'h28, 32'h0000_01C3);
    // Reserved bits below 31 and bit order
    wr(6'h00, 32'h7FFF_FFFC, 4'hF, 1'b0);
    rd(6'h00, MC_MASK & 32'h7FFF_FFFC);
    chk("order", 32'h1, {31'h0, bit_order_o});
    // Mode codes, only slave and master pick this interface
    for (int m = 0; m < 8; m++) begin
      wr(6'h00, {27'h0, m[2:0], 2'b00}, 4'hF, 1'b0);
      #1;
      chk("spi mode", {31'h0, m == 2 || m == 3}, {31'h0, spi_mode_o});
    end
    chk("order", 32'h0, {31'h0, bit_order_o});
    // Enable crossing, repeat while pending refused
    wr(6'h00, 32'h0000_000E, 4'hF, 1'b0);
    #1;
    chk("core enable", 32'h0, {31'h0, core_enable_o});
    wr(6'h00, 32'h0000_000E, 4'hF, 1'b1);
    repeat (4) @(posedge clk_i);
    #1;
    chk("core enable", 32'h1, {31'h0, core_enable_o});
    rd(6'h1C, 32'h0000_0000);
    // Enabled: protected fields hold
    wr(6'h00, 32'h4000_000E, 4'hF, 1'b0);
    rd(6'h00, 32'h0000_000E);
    repeat (4) @(posedge clk_i);
    wr(6'h04, 32'h0002_0007, 4'hF, 1'b0);
    wr(6'h04, 32'h0000_0000, 4'hF, 1'b1);
    rd(6'h04, 32'h0002_0000);
    chk("frame", 32'h0002_0000, frame_o);
    repeat (4) @(posedge clk_i);
    chk("core rx enable", 32'h1, {31'h0, core_rx_enable_o});
    // Soft reset keeps debug control only
    wr(6'h30, 32'h0000_0001, 4'b0001, 1'b0);
    wr(6'h00, 32'h4000_0003, 4'hF, 1'b0);
    #1;
    chk("ctrl", 32'h0000_0001, ctrl_o);
    wr(6'h0C, 32'h0000_0011, 4'b0001, 1'b1);
    repeat (4) @(posedge clk_i);
    rd(6'h00, 32'h0000_0000);
    rd(6'h04, 32'h0000_0000);
    rd(6'h24, 32'h0000_0000);
    rd(6'h0C, 32'h0000_0000);
    chk("core enable", 32'h0, {31'h0, core_enable_o});
    chk("core rx enable", 32'h0, {31'h0, core_rx_enable_o});
    chk("debug", 32'h1, {31'h0, halt_in_debug_o});
    chk("irq enable", 32'h0, {24'h0, irq_enable_o});
    summarize();
  end
endmodule
